// File: design/frt_timer.sv
// free running 16-bit timer counter with ahb-lite register slave
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module frt_timer
    import frt_pkg::*;
#(
    parameter bit EXT_PIN_BONDED = 1'b1
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic EXT_TICK_PIN,
    input wire logic CPU_IRQ_MASK,
    input wire logic HALT_MODE,
    output logic TIMER_IRQ,
    output logic IRQ
);
    import frt_pkg::*;

    logic [15:0] count_q;
    logic [7:0] low_latch_q;
    logic latch_pend_q;
    logic ovf_flag_q;
    logic ovf_armed_q;
    logic ovf_ie_q;
    logic [1:0] src_q;
    logic edge_q;
    logic [2:0] div_q;
    logic [2:0] ext_sync_q;
    logic irq_stat_q;
    logic irq_mask_q;
    logic ap_valid_q;
    logic ap_write_q;
    logic [7:0] ap_addr_q;
    logic [31:0] rdata_q;
    logic ext_in;
    logic ext_rise;
    logic ext_fall;
    logic tick;
    logic div_tick;
    logic [2:0] div_mask;
    logic wrap;
    logic addr_ok;
    logic rd_now;
    logic wr_now;
    logic low_wr;
    logic prim_low_acc;
    logic status_rd;
    logic high_rd;
    logic low_rd;
    logic [31:0] rdata_d;

    // address phase capture, zero wait state slave
    assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_q;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end
        else
        begin
            ap_valid_q <= addr_ok;
            ap_write_q <= HWRITE;
            ap_addr_q <= HADDR[7:0];
        end
    end

    // decoded accesses; reads act at address phase so data is ready
    assign rd_now = addr_ok && !HWRITE;
    assign wr_now = ap_valid_q && ap_write_q;
    assign high_rd = rd_now && (HADDR[7:0] == ADDR_COUNT_HIGH || HADDR[7:0] == ADDR_ALT_HIGH);
    assign low_rd = rd_now && (HADDR[7:0] == ADDR_COUNT_LOW || HADDR[7:0] == ADDR_ALT_LOW);
    assign status_rd = rd_now && HADDR[7:0] == ADDR_STATUS;
    assign low_wr = wr_now && (ap_addr_q == ADDR_COUNT_LOW || ap_addr_q == ADDR_ALT_LOW);
    assign prim_low_acc = (rd_now && HADDR[7:0] == ADDR_COUNT_LOW)
        || (wr_now && ap_addr_q == ADDR_COUNT_LOW);

    assign ext_in = EXT_PIN_BONDED ? EXT_TICK_PIN : 1'b1;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            ext_sync_q <= 3'b111;
        else
            ext_sync_q <= {ext_sync_q[1:0], ext_in};
    end

    // edge seen once stages two and three disagree in a settled way
    assign ext_rise = ext_sync_q[1] && !ext_sync_q[2];
    assign ext_fall = !ext_sync_q[1] && ext_sync_q[2];

    always_comb
    begin
        case (src_q)
            SRC_DIV2: div_mask = DIV_MASK2;
            SRC_DIV4: div_mask = DIV_MASK4;
            SRC_DIV8: div_mask = DIV_MASK8;
            default: div_mask = DIV_MASK8;
        endcase
    end

    // free divider from reset keeps twins in step
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            div_q <= 3'h0;
        else if (!HALT_MODE)
            div_q <= div_q + 3'h1;
    end

    assign div_tick = (div_q & div_mask) == div_mask;
    assign tick = HALT_MODE ? 1'b0
        : (src_q == SRC_EXT) ? (edge_q ? ext_rise : ext_fall) : div_tick;
    assign wrap = tick && count_q == COUNT_TOP;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            count_q <= COUNT_RESET;
        else if (low_wr)
            count_q <= COUNT_RESET;
        else if (tick)
            count_q <= count_q + 16'h0001;
    end

    // low byte buffer on high read
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            low_latch_q <= 8'h00;
            latch_pend_q <= 1'b0;
        end
        else if (high_rd && !latch_pend_q)
        begin
            low_latch_q <= count_q[7:0];
            latch_pend_q <= 1'b1;
        end
        else if (low_rd)
            latch_pend_q <= 1'b0;
    end

    // overflow flag, set wins over clear
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ovf_flag_q <= 1'b0;
            ovf_armed_q <= 1'b0;
        end
        else
        begin
            if (wrap)
                ovf_flag_q <= 1'b1;
            else if (ovf_armed_q && prim_low_acc)
                ovf_flag_q <= 1'b0;
            if (status_rd && ovf_flag_q)
                ovf_armed_q <= 1'b1;
            else if (prim_low_acc)
                ovf_armed_q <= 1'b0;
        end
    end

    // control registers and irq mask, written in data phase
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ovf_ie_q <= CTRL_RESET[OVF_IE_BIT];
            src_q <= CTRL_RESET[SRC_HI_BIT:SRC_LO_BIT];
            edge_q <= CTRL_RESET[EDGE_BIT];
            irq_mask_q <= 1'b0;
        end
        else if (wr_now)
        begin
            if (ap_addr_q == ADDR_CTRL_ONE)
                ovf_ie_q <= HWDATA[OVF_IE_BIT];
            if (ap_addr_q == ADDR_CTRL_TWO)
            begin
                src_q <= HWDATA[SRC_HI_BIT:SRC_LO_BIT];
                edge_q <= HWDATA[EDGE_BIT];
            end
            if (ap_addr_q == ADDR_IRQ_MASK)
                irq_mask_q <= HWDATA[OVF_BIT];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            irq_stat_q <= 1'b0;
        else if (wrap)
            irq_stat_q <= 1'b1;
        else if (wr_now && ap_addr_q == ADDR_IRQ_STATUS && HWDATA[OVF_BIT])
            irq_stat_q <= 1'b0;
    end

    // request held pending by flag until enabled and unmasked
    assign TIMER_IRQ = ovf_flag_q && ovf_ie_q && !CPU_IRQ_MASK;
    assign IRQ = irq_stat_q && irq_mask_q;

    // read mux, registered for the data phase
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (HADDR[7:0])
            ADDR_COUNT_HIGH, ADDR_ALT_HIGH: rdata_d[7:0] = count_q[15:8];
            ADDR_COUNT_LOW, ADDR_ALT_LOW:
                rdata_d[7:0] = latch_pend_q ? low_latch_q : count_q[7:0];
            ADDR_STATUS: rdata_d[OVF_BIT] = ovf_flag_q;
            ADDR_CTRL_ONE: rdata_d[OVF_IE_BIT] = ovf_ie_q;
            ADDR_CTRL_TWO:
            begin
                rdata_d[SRC_HI_BIT:SRC_LO_BIT] = src_q;
                rdata_d[EDGE_BIT] = edge_q;
            end
            ADDR_IRQ_STATUS: rdata_d[OVF_BIT] = irq_stat_q;
            ADDR_IRQ_MASK: rdata_d[OVF_BIT] = irq_mask_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rdata_q <= 32'h0000_0000;
        else if (rd_now)
            rdata_q <= rdata_d;
    end
endmodule

// File: design/frt_pkg.sv
// constants for the free running timer counter block
package frt_pkg;
    // register byte addresses (one register per aligned word)
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h00;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
    localparam logic [7:0] ADDR_ALT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_ALT_LOW = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h14;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    // field positions
    localparam int OVF_BIT = 5;
    localparam int OVF_IE_BIT = 7;
    localparam int SRC_LO_BIT = 2;
    localparam int SRC_HI_BIT = 3;
    localparam int EDGE_BIT = 0;
    // reset values and counter wrap value
    localparam logic [15:0] COUNT_RESET = 16'hfffc;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // tick source select codes and divider masks
    localparam logic [1:0] SRC_DIV2 = 2'b00;
    localparam logic [1:0] SRC_DIV4 = 2'b01;
    localparam logic [1:0] SRC_DIV8 = 2'b10;
    localparam logic [1:0] SRC_EXT = 2'b11;
    localparam logic [2:0] DIV_MASK2 = 3'h1;
    localparam logic [2:0] DIV_MASK4 = 3'h3;
    localparam logic [2:0] DIV_MASK8 = 3'h7;
    // least spacing of external edges in cpu clocks
    localparam int EXT_MIN_SPACING = 4;
    // htrans encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
endpackage

// File: verif/frt_checker.sv
// port assertions for the timer counter
`timescale 1ns/100ps
module frt_checker (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic CPU_IRQ_MASK,
    input wire logic HALT_MODE,
    input wire logic TIMER_IRQ,
    input wire logic IRQ
);
    logic tk;
    logic rd;
    // taken transfer and taken read
    assign tk = HSEL & HREADY & HTRANS[1];
    assign rd = tk & !HWRITE;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_rdy; HREADYOUT; endproperty
    a_rdy: assert property (p_rdy) else $error("ready low");
    property p_resp; !HRESP; endproperty
    a_resp: assert property (p_resp) else $error("error response");
    property p_mask; CPU_IRQ_MASK |-> !TIMER_IRQ; endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_hold; !$past(rd) |-> $stable(HRDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; rd && HADDR == 32'h40 |=> HRDATA == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_tfall; $fell(TIMER_IRQ) |-> CPU_IRQ_MASK || $past(tk) || $past(tk, 2); endproperty
    a_tfall: assert property (p_tfall) else $error("timer irq dropped");
    property p_ifall; $fell(IRQ) |-> $past(tk) || $past(tk, 2); endproperty
    a_ifall: assert property (p_ifall) else $error("irq dropped");
    property p_halt;
        HALT_MODE && $past(HALT_MODE, 2) && $rose(TIMER_IRQ)
            |-> $fell(CPU_IRQ_MASK) || $past(tk) || $past(tk, 2);
    endproperty
    a_halt: assert property (p_halt) else $error("irq rose in halt");
    c_tirq: cover property ($rose(TIMER_IRQ));
    c_irq: cover property ($rose(IRQ));
    c_unmap: cover property (rd && HADDR == 32'h40);
endmodule

// File: verif/frt_ext_src.sv
// external tick pin source model
`timescale 1ns/100ps
module frt_ext_src #(
    parameter int HALF = 4
)
(
    input wire logic clk,
    input wire logic run,
    output logic pin
);
    int cnt = 0;
    // active edges 2*HALF clocks apart, still when idle
    always @(posedge clk)
    begin
        if (run)
        begin
            cnt <= (cnt + 1) % HALF;
            if (cnt == HALF - 1)
                pin <= ~pin;
        end
    end
    initial pin = 1'b0;
endmodule

// File: verif/test_frt_timer.sv
// self-checking bench for the timer counter
`timescale 1ns/100ps
module test_frt_timer;
    import frt_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'b00;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic HALT_MODE = 1'b1;
    logic CPU_IRQ_MASK = 1'b0;
    logic ext_on = 1'b0;
    logic HREADY;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic EXT_TICK_PIN;
    logic TIMER_IRQ;
    logic IRQ;
    logic [31:0] q;
    logic [31:0] v;
    int dv;
    int miscompares = 0;
    int num_checks = 0;
    assign HREADY = HREADYOUT;
    frt_timer uut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_TICK_PIN(EXT_TICK_PIN),
        .CPU_IRQ_MASK(CPU_IRQ_MASK), .HALT_MODE(HALT_MODE), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ));
    frt_ext_src src (.clk(CLK), .run(ext_on), .pin(EXT_TICK_PIN));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one edge, then bounded wait for ready
    task automatic wt;
        int n;
        n = 0;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                miscompares++;
                complete_run;
            end
            @(posedge CLK);
        end
    endtask
    // single word transfer, read data into q
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        wt;
        HTRANS <= 2'b00;
        HWDATA <= d;
        wt;
        q = HRDATA;
    endtask
    // let the counter run k clocks, then freeze
    task automatic run(input int k);
        HALT_MODE <= 1'b0;
        ext_on <= 1'b1;
        repeat (k) @(posedge CLK);
        HALT_MODE <= 1'b1;
        ext_on <= 1'b0;
    endtask
    initial
    begin
        forever #4 CLK = ~CLK;
    end
    initial
    begin
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        xf(0, ADDR_COUNT_HIGH, 0);
        chk(q, 32'hff);
        xf(0, ADDR_COUNT_LOW, 0);
        chk(q, 32'hfc);
        xf(0, 8'h40, 0);
        chk(q, 32'h0);
        // each tick source: no wrap before four ticks, wrap after
        for (int i = 0; i < 5; i++)
        begin
            dv = (i < 3) ? (2 << i) : 8;
            xf(1, ADDR_CTRL_TWO, 32'((i < 4 ? i : 3) * 4 + (i == 4 ? 1 : 0)));
            xf(0, ADDR_STATUS, 0);
            xf(1, ADDR_COUNT_LOW, 0);
            run(3 * dv - 1);
            xf(0, ADDR_STATUS, 0);
            chk(q[OVF_BIT], 0);
            run(4 * dv);
            xf(0, ADDR_STATUS, 0);
            chk(q[OVF_BIT], 1);
        end
        // overflow interrupt, cpu mask, two-step clear
        xf(1, ADDR_CTRL_ONE, 32'h80);
        @(posedge CLK);
        chk(TIMER_IRQ, 1);
        CPU_IRQ_MASK <= 1'b1;
        repeat (2) @(posedge CLK);
        chk(TIMER_IRQ, 0);
        CPU_IRQ_MASK <= 1'b0;
        xf(0, ADDR_STATUS, 0);
        xf(0, ADDR_ALT_LOW, 0);
        xf(0, ADDR_STATUS, 0);
        chk(q[OVF_BIT], 1);
        xf(0, ADDR_COUNT_LOW, 0);
        @(posedge CLK);
        chk(TIMER_IRQ, 0);
        xf(1, ADDR_IRQ_MASK, 32'h20);
        @(posedge CLK);
        chk(IRQ, 1);
        xf(1, ADDR_IRQ_STATUS, 32'h20);
        @(posedge CLK);
        chk(IRQ, 0);
        // latched low byte across a wrap, then live reads
        xf(1, ADDR_ALT_LOW, 0);
        xf(0, ADDR_ALT_HIGH, 0);
        chk(q, 32'hff);
        run(40);
        xf(0, ADDR_ALT_HIGH, 0);
        chk(q, 32'h0);
        xf(0, ADDR_ALT_LOW, 0);
        chk(q, 32'hfc);
        xf(0, ADDR_ALT_LOW, 0);
        v = q;
        chk(q[7:1], 0);
        xf(0, ADDR_COUNT_LOW, 0);
        chk(q, v);
        // reset after a run, with the counter halted, reloads the count
        run(20);
        RST_N <= 1'b0;
        @(posedge CLK);
        RST_N <= 1'b1;
        xf(0, ADDR_COUNT_HIGH, 0);
        chk(q, 32'hff);
        xf(0, ADDR_ALT_LOW, 0);
        chk(q, 32'hfc);
        complete_run;
    end
endmodule
bind frt_timer frt_checker chk_i (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_IRQ_MASK(CPU_IRQ_MASK),
    .HALT_MODE(HALT_MODE), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ));
